// ---- hw/dls_pkg.sv ----
// Function
// - load mode held in bits 1:0, pointer 0x07
// - mode 00: written data reaches DAC at once
// - mode 01: data stays in input registers
// - mode 10: copy all, then mode becomes 01
// - pointer nibble 0101 selects DAC readback
// - readback word: 1, index, 12-bit value
// - DAC pointer 0001_0 plus 3-bit index
// - DAC write bytes land in input register
// - sequence write starts tracking first channel
// - one channel per transfer, ascending order
// - conversion starts at ACK before MSB
// - repeat restarts, else last result repeats
// - result word: 0, channel, 12-bit value
// - new sequence drops pending old channels
// - all sequence bits clear stops converting
// - sequence: repeat 9, temp 8, channels 7:0
// - repeat streams results until stop
//
// constants shared by the converter control block
// assumes nothing beyond the modules that import it
package dls_pkg;

   localparam int CH_N = 8;
   localparam int DAT_W = 12;
   localparam int IDX_W = 3;

   // pointer byte modes, bits 7:4
   localparam logic [3:0] PTR_CFG = 4'h0;
   localparam logic [3:0] PTR_DAC_WR = 4'h1;
   localparam logic [3:0] PTR_ADC_RD = 4'h4;
   localparam logic [3:0] PTR_DAC_RD = 4'h5;
   localparam int PTR_SEL_BIT = 3;

   // configuration register selectors, bits 3:0
   localparam logic [3:0] REG_SEQ = 4'h2;
   localparam logic [3:0] REG_LOAD = 4'h7;

   // load modes
   localparam logic [1:0] LM_AUTO = 2'h0;
   localparam logic [1:0] LM_HOLD = 2'h1;
   localparam logic [1:0] LM_ALL = 2'h2;
   localparam logic [1:0] LM_RST = LM_AUTO;

   // sequence register layout
   localparam int SEQ_W = 10;
   localparam int SEQ_REP = 9;
   localparam int SEQ_TEMP = 8;
   localparam logic [SEQ_W-1:0] SEQ_RST = 10'h000;

   // result word layout
   localparam int TAG_BIT = 15;
   localparam logic WORD_DAC = 1'b1;
   localparam logic WORD_ADC = 1'b0;

   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [15:0] WORD_ZERO = 16'h0000;

endpackage

// ---- hw/dls_cnv_if.sv ----
// signals between the serial engine and the two banks
// assumes one clock domain for all three modules
`timescale 1ns/10ps
interface dls_cnv_if;
   logic dac_wr;
   logic [2:0] dac_idx;
   logic [15:0] wr_word;
   logic mode_wr;
   logic [11:0] rd_data;
   logic [1:0] load_mode;
   logic seq_wr;
   logic conv_go;
   logic [15:0] result;
   logic [9:0] seq;
   modport ctl (output dac_wr, dac_idx, wr_word, mode_wr, seq_wr, conv_go,
      input rd_data, load_mode, result, seq);
   modport dac (input dac_wr, dac_idx, wr_word, mode_wr,
      output rd_data, load_mode);
   modport adc (input wr_word, seq_wr, conv_go, output result, seq);
endinterface

// ---- hw/dls_dac_bank.sv ----
// DAC input and output registers with load mode
// assumes strobes are one-cycle pulses on clk
`timescale 1ns/10ps
module dls_dac_bank
   import dls_pkg::*;
#(
   parameter int CH = CH_N
) (
   input wire logic clk,
   input wire logic rst_n,
   dls_cnv_if.dac cif,
   output logic [CH*DAT_W-1:0] dac_code
);
   typedef struct packed {
      logic [CH-1:0][DAT_W-1:0] inp;
      logic [CH-1:0][DAT_W-1:0] dac;
      logic [1:0] mode;
   } dls_dac_s;

   dls_dac_s q, d;

   always_comb begin
      d = q;
      if (cif.dac_wr) begin
         d.inp[cif.dac_idx] = cif.wr_word[DAT_W-1:0];
         if (q.mode == LM_AUTO) begin
            d.dac[cif.dac_idx] = cif.wr_word[DAT_W-1:0];
         end
      end
      if (cif.mode_wr) begin
         if (cif.wr_word[1:0] == LM_ALL) begin
            d.dac = q.inp;
            d.mode = LM_HOLD;
         end else begin
            d.mode = cif.wr_word[1:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q <= '{inp: '0, dac: '0, mode: LM_RST};
      end else begin
         q <= d;
      end
   end

   assign cif.rd_data = q.inp[cif.dac_idx];
   assign cif.load_mode = q.mode;
   assign dac_code = q.dac;
endmodule

// ---- hw/dls_adc_seq.sv ----
// channel sequencer tagging each result with its channel bits 2:0, so temperature tags as 0
// assumes sample is valid for the tracked channel
`timescale 1ns/10ps
module dls_adc_seq
   import dls_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   dls_cnv_if.adc cif,
   input wire logic [DAT_W-1:0] sample,
   output logic [3:0] channel,
   output logic convert
);
   typedef struct packed {
      logic [SEQ_W-1:0] seq;
      logic [8:0] pend;
      logic [15:0] res;
      logic [3:0] ch;
      logic go;
   } dls_adc_s;

   dls_adc_s q, d;
   logic [8:0] nxt;

   // lowest pending channel, temperature last
   function automatic logic [3:0] first_ch(input logic [8:0] p);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 8; i >= 0; i--) begin
         if (p[i]) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction

   always_comb begin
      d = q;
      d.go = 1'b0;
      nxt = q.pend & ~(9'h001 << q.ch);
      if (nxt == 9'h000 && q.seq[SEQ_REP]) begin
         nxt = q.seq[8:0];
      end
      if (cif.seq_wr) begin
         d.seq = cif.wr_word[SEQ_W-1:0];
         d.pend = cif.wr_word[8:0];
         d.ch = first_ch(cif.wr_word[8:0]);
      end else if (cif.conv_go && q.pend != 9'h000) begin
         d.go = 1'b1;
         d.res = {WORD_ADC, q.ch[2:0], sample};
         d.pend = nxt;
         if (nxt != 9'h000) begin
            d.ch = first_ch(nxt);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q <= '{seq: SEQ_RST, pend: '0, res: '0, ch: '0, go: 1'b0};
      end else begin
         q <= d;
      end
   end

   assign cif.result = q.res;
   assign cif.seq = q.seq;
   assign channel = q.ch;
   assign convert = q.go;
endmodule

// ---- hw/dls_top.sv ----
// two-wire serial slave in front of DAC bank and ADC sequencer
// assumes SCL and SDA_IN are asynchronous pins, SDA is open drain
`timescale 1ns/10ps
module dls_top
   import dls_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h10, // arbitrary
   parameter int CH = CH_N
) (
   input wire logic REF_CLK,
   input wire logic RESETN,
   input wire logic SCL,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   input wire logic [DAT_W-1:0] ADC_SAMPLE,
   output logic [3:0] ADC_CHANNEL,
   output logic ADC_CONVERT,
   output logic [CH*DAT_W-1:0] DAC_CODE
);

   // ***************************************************
   // state
   // ***************************************************

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_WR_BYTE,
      ST_WR_ACK,
      ST_RD_BYTE,
      ST_RD_ACK
   } dls_st_e;

   typedef struct packed {
      dls_st_e st;
      logic [2:0] scl_sy;
      logic [2:0] sda_sy;
      logic [2:0] cnt;
      logic got;
      logic [7:0] sh;
      logic rw;
      logic [1:0] wbyte;
      logic [7:0] ptr;
      logic [7:0] msb;
      logic [15:0] word;
      logic half;
      logic nack;
      logic sda_oe;
   } dls_ctl_s;

   dls_ctl_s q, d;

   dls_cnv_if cif ();

   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic sda_bit;
   logic adc_ptr;
   logic [15:0] rd_word;
   logic dac_wr;
   logic mode_wr;
   logic seq_wr;
   logic conv_go;

   // ***************************************************
   // pin edges
   // ***************************************************

   assign sda_bit = q.sda_sy[1];
   assign scl_rise = q.scl_sy[1] & ~q.scl_sy[2];
   assign scl_fall = ~q.scl_sy[1] & q.scl_sy[2];
   assign bus_start = q.scl_sy[1] & q.scl_sy[2] & ~q.sda_sy[1] & q.sda_sy[2];
   assign bus_stop = q.scl_sy[1] & q.scl_sy[2] & q.sda_sy[1] & ~q.sda_sy[2];

   // ***************************************************
   // pointer decode
   // ***************************************************

   function automatic logic ptr_is_load(input logic [7:0] p);
      return (p[7:4] == PTR_CFG) && (p[3:0] == REG_LOAD);
   endfunction

   function automatic logic ptr_is_seq(input logic [7:0] p);
      return (p[7:4] == PTR_CFG) && (p[3:0] == REG_SEQ);
   endfunction

   // bit 3 set is not a DAC address
   function automatic logic ptr_is_dac_wr(input logic [7:0] p);
      return (p[7:4] == PTR_DAC_WR) && !p[PTR_SEL_BIT];
   endfunction

   // ***************************************************
   // read word source
   // ***************************************************

   assign adc_ptr = (q.ptr[7:4] == PTR_ADC_RD);

   always_comb begin
      unique case (q.ptr[7:4])
         PTR_DAC_RD: begin
            rd_word = {WORD_DAC, q.ptr[2:0], cif.rd_data};
         end
         PTR_ADC_RD: begin
            rd_word = cif.result;
         end
         PTR_CFG: begin
            if (ptr_is_load(q.ptr)) begin
               rd_word = {14'h0000, cif.load_mode};
            end else if (ptr_is_seq(q.ptr)) begin
               rd_word = {6'h00, cif.seq};
            end else begin
               rd_word = WORD_ZERO;
            end
         end
         default: begin
            rd_word = WORD_ZERO;
         end
      endcase
   end

   // ***************************************************
   // serial engine
   // ***************************************************

   always_comb begin
      d = q;
      dac_wr = 1'b0;
      mode_wr = 1'b0;
      seq_wr = 1'b0;
      conv_go = 1'b0;
      d.scl_sy = {q.scl_sy[1:0], SCL};
      d.sda_sy = {q.sda_sy[1:0], SDA_IN};
      if (bus_start) begin
         d.st = ST_ADDR;
         d.cnt = 3'h0;
         d.got = 1'b0;
         d.sda_oe = 1'b0;
      end else if (bus_stop) begin
         d.st = ST_IDLE;
         d.sda_oe = 1'b0;
      end else begin
         unique case (q.st)
            ST_IDLE: begin
               d.sda_oe = 1'b0;
            end
            ST_ADDR: begin
               if (scl_rise) begin
                  d.sh = {q.sh[6:0], sda_bit};
                  d.cnt = q.cnt + 3'h1;
                  d.got = (q.cnt == BIT_LAST);
               end else if (scl_fall && q.got) begin
                  d.got = 1'b0;
                  if (q.sh[7:1] == DEV_ADDR) begin
                     d.st = ST_ADDR_ACK;
                     d.sda_oe = 1'b1;
                     d.rw = q.sh[0];
                     d.wbyte = 2'h0;
                  end else begin
                     d.st = ST_IDLE;
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (scl_rise && q.rw && adc_ptr) begin
                  conv_go = 1'b1;
               end
               if (scl_fall) begin
                  d.cnt = 3'h0;
                  if (q.rw) begin
                     d.st = ST_RD_BYTE;
                     d.word = rd_word;
                     d.sh = rd_word[15:8];
                     d.half = 1'b0;
                     d.sda_oe = ~rd_word[15];
                  end else begin
                     d.st = ST_WR_BYTE;
                     d.sda_oe = 1'b0;
                  end
               end
            end
            ST_WR_BYTE: begin
               if (scl_rise) begin
                  d.sh = {q.sh[6:0], sda_bit};
                  d.cnt = q.cnt + 3'h1;
                  d.got = (q.cnt == BIT_LAST);
               end else if (scl_fall && q.got) begin
                  d.got = 1'b0;
                  d.st = ST_WR_ACK;
                  d.sda_oe = 1'b1;
                  unique case (q.wbyte)
                     2'h0: begin
                        d.ptr = q.sh;
                        d.wbyte = 2'h1;
                     end
                     2'h1: begin
                        d.msb = q.sh;
                        d.wbyte = 2'h2;
                     end
                     default: begin
                        d.wbyte = 2'h1;
                        if (ptr_is_load(q.ptr)) begin
                           mode_wr = 1'b1;
                        end
                        if (ptr_is_seq(q.ptr)) begin
                           seq_wr = 1'b1;
                        end
                        if (ptr_is_dac_wr(q.ptr)) begin
                           dac_wr = 1'b1;
                        end
                     end
                  endcase
               end
            end
            ST_WR_ACK: begin
               if (scl_fall) begin
                  d.st = ST_WR_BYTE;
                  d.sda_oe = 1'b0;
                  d.cnt = 3'h0;
               end
            end
            ST_RD_BYTE: begin
               if (scl_fall) begin
                  d.cnt = q.cnt + 3'h1;
                  if (q.cnt == BIT_LAST) begin
                     d.st = ST_RD_ACK;
                     d.sda_oe = 1'b0;
                  end else begin
                     d.sh = {q.sh[6:0], 1'b0};
                     d.sda_oe = ~q.sh[6];
                  end
               end
            end
            ST_RD_ACK: begin
               if (scl_rise) begin
                  d.nack = sda_bit;
                  if (!sda_bit && q.half && adc_ptr) begin
                     conv_go = 1'b1;
                  end
               end else if (scl_fall) begin
                  d.cnt = 3'h0;
                  if (q.nack) begin
                     d.st = ST_IDLE;
                  end else if (!q.half) begin
                     d.st = ST_RD_BYTE;
                     d.sh = q.word[7:0];
                     d.half = 1'b1;
                     d.sda_oe = ~q.word[7];
                  end else begin
                     d.st = ST_RD_BYTE;
                     d.word = rd_word;
                     d.sh = rd_word[15:8];
                     d.half = 1'b0;
                     d.sda_oe = ~rd_word[15];
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RESETN) begin
         q <= '{st: ST_IDLE, scl_sy: 3'h7, sda_sy: 3'h7, cnt: '0, got: 1'b0,
            sh: '0, rw: 1'b0, wbyte: '0, ptr: '0, msb: '0, word: '0,
            half: 1'b0, nack: 1'b0, sda_oe: 1'b0};
      end else begin
         q <= d;
      end
   end

   // ***************************************************
   // bank connections
   // ***************************************************

   assign cif.dac_wr = dac_wr;
   assign cif.mode_wr = mode_wr;
   assign cif.seq_wr = seq_wr;
   assign cif.conv_go = conv_go;
   assign cif.dac_idx = q.ptr[2:0];
   assign cif.wr_word = {q.msb, q.sh};

   dls_dac_bank #(
      .CH(CH)
   ) u_dac (
      .clk(REF_CLK),
      .rst_n(RESETN),
      .cif(cif.dac),
      .dac_code(DAC_CODE)
   );

   dls_adc_seq u_adc (
      .clk(REF_CLK),
      .rst_n(RESETN),
      .cif(cif.adc),
      .sample(ADC_SAMPLE),
      .channel(ADC_CHANNEL),
      .convert(ADC_CONVERT)
   );

   assign SDA_OUT = 1'b0;
   assign SDA_OE = q.sda_oe;
endmodule

// ---- bench/dls_monitor.sv ----
// checker on the ports of the converter control top
// assumes it is bound into dls_top, one clock domain
`timescale 1ns/10ps
module dls_monitor
   import dls_pkg::*;
#(
   parameter int CH = CH_N
) (
   input wire logic REF_CLK,
   input wire logic RESETN,
   input wire logic SCL,
   input wire logic SDA_IN,
   input wire logic SDA_OUT,
   input wire logic SDA_OE,
   input wire logic [DAT_W-1:0] ADC_SAMPLE,
   input wire logic [3:0] ADC_CHANNEL,
   input wire logic ADC_CONVERT,
   input wire logic [CH*DAT_W-1:0] DAC_CODE
);
   // cycles since the serial clock pin last rose
   logic scl_q;
   logic [3:0] rise_q;
   always_ff @(posedge REF_CLK) begin
      scl_q <= SCL;
      if (!RESETN) begin
         rise_q <= 4'hF;
      end else if (SCL && !scl_q) begin
         rise_q <= 4'h0;
      end else if (rise_q != 4'hF) begin
         rise_q <= rise_q + 4'h1;
      end
   end
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RESETN);
   property p_out_zero; SDA_OUT == 1'b0; endproperty
   a_out_zero: assert property (p_out_zero) else $error("data pin value not low");
   property p_oe_len; $rose(SDA_OE) |-> SDA_OE [*8]; endproperty
   a_oe_len: assert property (p_oe_len) else $error("driven bit shorter than one bit");
   property p_oe_scl_low; $changed(SDA_OE) |-> !SCL; endproperty
   a_oe_scl_low: assert property (p_oe_scl_low) else $error("data changed with clock high");
   property p_dac_scl_low; $changed(DAC_CODE) |-> !SCL; endproperty
   a_dac_scl_low: assert property (p_dac_scl_low) else $error("dac code changed off a byte end");
   property p_conv_pulse; ADC_CONVERT |=> !ADC_CONVERT [*8]; endproperty
   a_conv_pulse: assert property (p_conv_pulse) else $error("conversions too close");
   property p_conv_scl; ADC_CONVERT |-> rise_q <= 4'h5; endproperty
   a_conv_scl: assert property (p_conv_scl) else $error("conversion not at clock rise");
   property p_chan_range; ADC_CHANNEL <= 4'h8; endproperty
   a_chan_range: assert property (p_chan_range) else $error("channel out of range");
   property p_reset_vals;
      $rose(RESETN) |-> !SDA_OE && !ADC_CONVERT && ADC_CHANNEL == 4'h0 && DAC_CODE == '0;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("outputs not at reset state");
   c_convert: cover property (ADC_CONVERT);
   c_dac: cover property ($changed(DAC_CODE));
   c_temp: cover property (ADC_CHANNEL == 4'h8);
endmodule
bind dls_top dls_monitor #(.CH(CH)) mon_u (.REF_CLK(REF_CLK), .RESETN(RESETN), .SCL(SCL),
   .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .ADC_SAMPLE(ADC_SAMPLE),
   .ADC_CHANNEL(ADC_CHANNEL), .ADC_CONVERT(ADC_CONVERT), .DAC_CODE(DAC_CODE));

// ---- bench/dls_host.sv ----
// two-wire bus controller model, one bit per 8 clocks
// assumes an open-drain wire with pull-up built by the bench
`timescale 1ns/10ps
module dls_host (
   input wire logic clk,
   output logic scl,
   output logic sda_m,
   input wire logic sda_w
);
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // low 6 clocks, high 2; data set mid low
   task automatic bit_io(input logic b, output logic r);
      scl <= 1'b0;
      tick(3);
      sda_m <= b;
      tick(3);
      scl <= 1'b1;
      tick(1);
      r = sda_w;
      tick(1);
   endtask
   task automatic start();
      sda_m <= 1'b1;
      scl <= 1'b1;
      tick(4);
      sda_m <= 1'b0;
      tick(4);
   endtask
   task automatic stop();
      scl <= 1'b0;
      tick(3);
      sda_m <= 1'b0;
      tick(3);
      scl <= 1'b1;
      tick(3);
      sda_m <= 1'b1;
      tick(8);
   endtask
   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(b[i], r);
      bit_io(1'b1, r);
      ack = !r;
   endtask
   task automatic get_byte(input logic nack, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
      bit_io(nack, r);
   endtask
endmodule

// ---- bench/tb_dac_load_adc_sequencer.sv ----
// self-checking bench for the converter control top
// assumes dls_host drives the bus, bench feeds samples
`timescale 1ns/10ps
module tb_dac_load_adc_sequencer;
   import dls_pkg::*;
   logic ref_clk = 1'b0;
   logic resetn, scl, sda_m, sda_out, sda_oe, adc_convert;
   wire sda_w;
   logic [11:0] adc_sample;
   logic [3:0] adc_channel;
   logic [95:0] dac_code;
   logic [15:0] rq [$];
   int n_errors, n_tests, c0;
   int n_conv = 0;
   logic [15:0] seqs [3] = '{16'h0081, 16'h0281, 16'h0104};
   logic [3:0] first_c [3] = '{4'h0, 4'h0, 4'h2};
   logic [15:0] exp_w [3][3] = '{'{16'h0A50, 16'h7A57, 16'h7A57},
      '{16'h0A50, 16'h7A57, 16'h0A50}, '{16'h2A52, 16'h0A58, 16'h0A58}};
   int exp_c [3] = '{2, 3, 2};
   assign sda_w = sda_m & ~sda_oe;
   always #12.5 ref_clk = ~ref_clk;
   // sample tells its channel apart
   always @(posedge ref_clk) adc_sample <= {8'hA5, adc_channel};
   always @(posedge ref_clk) if (adc_convert === 1'b1) n_conv <= n_conv + 1;
   dls_top #(.DEV_ADDR(7'h10)) dut_u (.REF_CLK(ref_clk), .RESETN(resetn), .SCL(scl), .SDA_IN(sda_w),
      .SDA_OUT(sda_out), .SDA_OE(sda_oe), .ADC_SAMPLE(adc_sample), .ADC_CHANNEL(adc_channel),
      .ADC_CONVERT(adc_convert), .DAC_CODE(dac_code));
   dls_host host_u (.clk(ref_clk), .scl(scl), .sda_m(sda_m), .sda_w(sda_w));
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   function automatic logic [15:0] lane(input int n);
      return {4'h0, dac_code[12*n +: 12]};
   endfunction
   task automatic wr(input logic [7:0] ptr, input logic [15:0] w, input bit data);
      logic a0, a1, a2, a3;
      a2 = 1'b1;
      a3 = 1'b1;
      host_u.start();
      host_u.put_byte({7'h10, 1'b0}, a0);
      host_u.put_byte(ptr, a1);
      if (data) begin
         host_u.put_byte(w[15:8], a2);
         host_u.put_byte(w[7:0], a3);
      end
      host_u.stop();
      chk("write acks", 16'h000F, {12'h000, a0, a1, a2, a3});
   endtask
   task automatic rd(input logic [7:0] ptr, input int n);
      logic a;
      logic [7:0] hi, lo;
      wr(ptr, 16'h0000, 0);
      host_u.start();
      host_u.put_byte({7'h10, 1'b1}, a);
      chk("read ack", 16'h0001, {15'h0000, a});
      rq.delete();
      for (int i = 0; i < n; i++) begin
         host_u.get_byte(1'b0, hi);
         host_u.get_byte(i == n - 1, lo);
         rq.push_back({hi, lo});
      end
      host_u.stop();
   endtask
   initial begin
      n_errors = 0;
      n_tests = 0;
      resetn = 1'b0;
      repeat (12) @(posedge ref_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk("lane2", 16'h0000, lane(2));
      wr(8'h12, 16'h0ABC, 1);
      chk("lane2", 16'h0ABC, lane(2));
      wr(8'h1A, 16'h0123, 1);
      chk("lane2", 16'h0ABC, lane(2));
      wr(8'h07, 16'h0001, 1);
      wr(8'h15, 16'h0555, 1);
      chk("lane5", 16'h0000, lane(5));
      rd(8'h55, 1);
      chk("readback", 16'hD555, rq[0]);
      wr(8'h07, 16'h0002, 1);
      chk("lane5", 16'h0555, lane(5));
      rd(8'h07, 1);
      chk("load mode", 16'h0001, rq[0]);
      wr(8'h15, 16'h0666, 1);
      chk("lane5", 16'h0555, lane(5));
      wr(8'h07, 16'h0003, 1);
      wr(8'h11, 16'h0111, 1);
      chk("lane1", 16'h0000, lane(1));
      rd(8'h51, 1);
      chk("readback", 16'h9111, rq[0]);
      for (int k = 0; k < 3; k++) begin
         wr(8'h02, seqs[k], 1);
         chk("first channel", {12'h000, first_c[k]}, {12'h000, adc_channel});
         c0 = n_conv;
         rd(8'h40, 3);
         for (int j = 0; j < 3; j++) chk("adc word", exp_w[k][j], rq[j]);
         chk("conversions", 16'(exp_c[k]), 16'(n_conv - c0));
      end
      rd(8'h02, 1);
      chk("sequence", 16'h0104, rq[0]);
      wr(8'h02, 16'h0000, 1);
      c0 = n_conv;
      rd(8'h40, 2);
      chk("halted", 16'h0000, 16'(n_conv - c0));
      give_verdict();
   end
   initial begin
      #1000000;
      n_errors++;
      $display("BAD watchdog expected done seen hang");
      give_verdict();
   end
endmodule
